/* rtl/reading_trigger_control.sv */
// Purpose: Opens and closes the reading pulse from sensor or reflector polling
// Assumes: Inputs synchronous to core_clk_i; scan_strobe_i pulses once per scan
// Notes: Decoding itself sits outside; this block gates and frames it
`timescale 1ns/1ps
module reading_trigger_control
  import reading_trigger_pkg::*;
#(
  parameter int unsigned SELFTEST_LEN = SELFTEST_CYCLES,
  parameter int unsigned BEEP_LEN = BEEP_CYCLES
)
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic trig_src_reflector_i,
  input wire logic quality_mode_i,
  input wire logic sensor_i,
  input wire logic scan_strobe_i,
  input wire logic reflector_seen_i,
  input wire logic selftest_ok_i,
  input wire logic code_valid_i,
  input wire logic [31:0] code_data_i,
  input wire logic code_is_reflector_i,
  output logic reading_pulse_o,
  output logic laser_on_o,
  output logic decode_enable_o,
  output logic result_valid_o,
  output logic [31:0] result_data_o,
  output logic [31:0] result_tag_o,
  output logic beeper_o,
  output logic ready_o
);
  power_state_t power_state, next_power_state;
  logic [23:0] power_timer, next_power_timer;
  logic trig_src, next_trig_src;
  poll_state_t poll_state, next_poll_state;
  logic [4:0] scan_count, next_scan_count;
  logic pulse, next_pulse;
  logic result_valid, next_result_valid;
  logic [31:0] result_data, next_result_data;
  logic [31:0] result_tag, next_result_tag;
  logic [31:0] held_data, next_held_data;
  logic held, next_held;
  logic poll_scan;
  logic ready;
  logic refl_close;
  logic beep_done;

  assign ready = (power_state == PWR_READY);
  // Laser forced on only on the check scan; reading pulse drives it otherwise
  assign poll_scan = scan_strobe_i && (scan_count == POLL_INTERVAL_SCANS - 5'h01);
  assign refl_close = ready && (trig_src == TRIG_SRC_REFLECTOR) && (poll_state == POLL_OPEN)
                      && scan_strobe_i && reflector_seen_i;
  assign beep_done = (power_timer >= 24'(BEEP_LEN));

  // Power-up sequence
  always_comb
  begin
    next_power_state = power_state;
    next_power_timer = power_timer + 24'h000001;
    unique case (power_state)
      PWR_SELFTEST:
      begin
        // Stays here on a failed test; no beep means fault
        if (power_timer >= 24'(SELFTEST_LEN) && selftest_ok_i)
        begin
          next_power_state = PWR_BEEP_ONE;
          next_power_timer = TIMER_RESET;
        end
      end
      PWR_BEEP_ONE:
      begin
        if (beep_done)
        begin
          next_power_state = PWR_PAUSE;
          next_power_timer = TIMER_RESET;
        end
      end
      PWR_PAUSE:
      begin
        if (beep_done)
        begin
          next_power_state = PWR_BEEP_TWO;
          next_power_timer = TIMER_RESET;
        end
      end
      PWR_BEEP_TWO:
      begin
        if (beep_done)
        begin
          next_power_state = PWR_GAP;
          next_power_timer = TIMER_RESET;
        end
      end
      PWR_GAP:
      begin
        if (beep_done)
        begin
          next_power_state = PWR_BEEP_THREE;
          next_power_timer = TIMER_RESET;
        end
      end
      PWR_BEEP_THREE:
      begin
        if (beep_done)
        begin
          next_power_state = PWR_READY;
          next_power_timer = TIMER_RESET;
        end
      end
      PWR_READY:
      begin
        next_power_timer = power_timer;
      end
      default:
      begin
        next_power_state = PWR_SELFTEST;
        next_power_timer = TIMER_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      power_state <= PWR_SELFTEST;
      power_timer <= TIMER_RESET;
    end
    else
    begin
      power_state <= next_power_state;
      power_timer <= next_power_timer;
    end
  end

  // Trigger source
  always_comb
  begin
    next_trig_src = trig_src;
    // Source only changes between pulses, so only a change in the cycle a pulse opens can cut it
    if (!pulse)
    begin
      next_trig_src = trig_src_reflector_i ? TRIG_SRC_REFLECTOR : TRIG_SRC_SENSOR;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      trig_src <= TRIG_SRC_RESET;
    end
    else
    begin
      trig_src <= next_trig_src;
    end
  end

  // Scan counter
  always_comb
  begin
    next_scan_count = scan_count;
    // Held clear until reading mode, so the first check is a full interval in
    if (!ready)
    begin
      next_scan_count = POLL_COUNT_RESET;
    end
    else if (refl_close)
    begin
      next_scan_count = POLL_COUNT_RESET;
    end
    else if (scan_strobe_i)
    begin
      next_scan_count = poll_scan ? POLL_COUNT_RESET : scan_count + 5'h01;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      scan_count <= POLL_COUNT_RESET;
    end
    else
    begin
      scan_count <= next_scan_count;
    end
  end

  // Trigger state
  always_comb
  begin
    next_poll_state = poll_state;
    next_pulse = 1'b0;
    if (!ready)
    begin
      next_poll_state = POLL_ARM;
    end
    else if (trig_src == TRIG_SRC_SENSOR)
    begin
      next_pulse = sensor_i;
      next_poll_state = POLL_ARM;
    end
    else
    begin
      unique case (poll_state)
        POLL_ARM:
        begin
          if (poll_scan && reflector_seen_i)
          begin
            next_poll_state = POLL_IDLE;
          end
        end
        POLL_IDLE:
        begin
          // Decided on the check scan itself, well inside the start bound
          if (poll_scan && !reflector_seen_i)
          begin
            next_poll_state = POLL_OPEN;
            next_pulse = 1'b1;
          end
        end
        POLL_OPEN:
        begin
          next_pulse = 1'b1;
          // Laser runs every scan while open, so any scan can close it
          if (refl_close)
          begin
            next_poll_state = POLL_IDLE;
            next_pulse = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      poll_state <= POLL_ARM;
      pulse <= 1'b0;
    end
    else
    begin
      poll_state <= next_poll_state;
      pulse <= next_pulse;
    end
  end

  // Result framing
  always_comb
  begin
    next_result_valid = 1'b0;
    next_result_data = result_data;
    next_result_tag = result_tag;
    next_held_data = held_data;
    next_held = held;
    // Only the last code of a pulse is kept; no buffer for more
    if (pulse && code_valid_i && !code_is_reflector_i)
    begin
      next_held_data = code_data_i;
      next_held = 1'b1;
    end
    // Not in the cycle a pulse opens, so a report never overlaps a pulse
    if (!pulse && !next_pulse && held == 1'b0 && quality_mode_i && ready
        && code_valid_i && code_is_reflector_i)
    begin
      next_result_valid = 1'b1;
      next_result_data = code_data_i;
      next_result_tag = REFLECTOR_RESULT_TAG;
    end
    // A code arriving on the closing cycle still makes it out
    if (pulse && !next_pulse && next_held)
    begin
      next_result_valid = 1'b1;
      next_result_data = next_held_data;
      next_result_tag = 32'h00000000;
      next_held = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      result_valid <= 1'b0;
      result_data <= 32'h00000000;
      result_tag <= 32'h00000000;
      held_data <= 32'h00000000;
      held <= 1'b0;
    end
    else
    begin
      result_valid <= next_result_valid;
      result_data <= next_result_data;
      result_tag <= next_result_tag;
      held_data <= next_held_data;
      held <= next_held;
    end
  end

  assign reading_pulse_o = pulse;
  assign decode_enable_o = pulse || quality_mode_i;
  assign laser_on_o = pulse || (ready && trig_src == TRIG_SRC_REFLECTOR && poll_scan);
  assign result_valid_o = result_valid;
  assign result_data_o = result_data;
  assign result_tag_o = result_tag;
  assign beeper_o = (power_state == PWR_BEEP_ONE) || (power_state == PWR_BEEP_TWO)
                    || (power_state == PWR_BEEP_THREE);
  assign ready_o = ready;
endmodule

/* rtl/reading_trigger_pkg.sv */
// Purpose: Constants and types for the reading trigger control block
// Assumes: 100 MHz core clock, scan timing given by a scan strobe input
// Notes: Times are in their own unit with derived cycle counts
package reading_trigger_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam logic [4:0] POLL_INTERVAL_SCANS = 5'h14;
  localparam logic [4:0] POLL_COUNT_RESET = 5'h00;
  localparam int unsigned START_DELAY_MS = 25;
  localparam int unsigned START_DELAY_CYCLES = (CLK_HZ / 1000) * START_DELAY_MS;
  localparam int unsigned SELFTEST_MS = 100;
  localparam int unsigned SELFTEST_CYCLES = (CLK_HZ / 1000) * SELFTEST_MS;
  localparam int unsigned BEEP_MS = 100;
  localparam int unsigned BEEP_CYCLES = (CLK_HZ / 1000) * BEEP_MS;
  localparam logic [1:0] BEEPS_AFTER_TEST = 2'h1;
  localparam logic [1:0] BEEPS_READY = 2'h2;
  localparam logic TRIG_SRC_SENSOR = 1'b0;
  localparam logic TRIG_SRC_REFLECTOR = 1'b1;
  localparam logic TRIG_SRC_RESET = TRIG_SRC_SENSOR;
  localparam logic [31:0] REFLECTOR_RESULT_TAG = 32'h5245504f;
  localparam logic [23:0] TIMER_RESET = 24'h000000;

  typedef enum logic [2:0] {
    PWR_SELFTEST,
    PWR_BEEP_ONE,
    PWR_PAUSE,
    PWR_BEEP_TWO,
    PWR_GAP,
    PWR_BEEP_THREE,
    PWR_READY
  } power_state_t;

  typedef enum logic [1:0] {
    POLL_ARM,
    POLL_IDLE,
    POLL_OPEN
  } poll_state_t;
endpackage

/* verification/rtc_monitor.sv */
// Purpose: Timing checks on the reading trigger ports
// Assumes: Bound into reading_trigger_control
// Notes: Poll count restarts at each check scan and pulse
`timescale 1ns/1ps
module rtc_monitor
  import reading_trigger_pkg::*;
(
  input logic core_clk_i,
  input logic reset_i,
  input logic trig_src_reflector_i,
  input logic quality_mode_i,
  input logic sensor_i,
  input logic scan_strobe_i,
  input logic reflector_seen_i,
  input logic reading_pulse_o,
  input logic laser_on_o,
  input logic decode_enable_o,
  input logic result_valid_o,
  input logic [31:0] result_tag_o,
  input logic ready_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  always_comb
  begin
    next_cnt = cnt;
    if (!ready_o || reading_pulse_o || (scan_strobe_i && laser_on_o))
      next_cnt = 5'h00;
    else if (scan_strobe_i)
      next_cnt = cnt + 5'h01;
  end
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      cnt <= 5'h00;
    else
      cnt <= next_cnt;
  end
  sequence s_seen_in_pulse;
    ready_o && trig_src_reflector_i && reading_pulse_o && scan_strobe_i && reflector_seen_i;
  endsequence
  sequence s_closed;
    !reading_pulse_o;
  endsequence
  a_no_early_pulse: assert property (!ready_o |-> !reading_pulse_o)
    else $error("pulse before ready");
  a_result_on_close: assert property (result_valid_o && result_tag_o == 32'h0
    |-> $fell(reading_pulse_o)) else $error("result not at close");
  a_tag_value: assert property (result_valid_o && result_tag_o != 32'h0
    |-> result_tag_o == REFLECTOR_RESULT_TAG && !reading_pulse_o)
    else $error("bad reflector tag");
  a_decode_gate: assert property (decode_enable_o == (reading_pulse_o || quality_mode_i))
    else $error("decode gate wrong");
  a_sensor_follow: assert property (ready_o && !trig_src_reflector_i && !reading_pulse_o
    |=> reading_pulse_o == $past(sensor_i)) else $error("sensor not followed");
  a_refl_close: assert property (s_seen_in_pulse |=> s_closed)
    else $error("pulse not closed");
  a_laser_gate: assert property (laser_on_o
    |-> reading_pulse_o || (scan_strobe_i && trig_src_reflector_i))
    else $error("laser outside check");
  a_poll_spacing: assert property (scan_strobe_i && laser_on_o && !reading_pulse_o
    |-> cnt == 5'h13) else $error("check spacing wrong");
endmodule
bind reading_trigger_control rtc_monitor rtc_monitor_inst (.*);

/* verification/scan_partner.sv */
// Purpose: Presence sensor and polling reflector model
// Assumes: One scan every four core cycles
// Notes: Reflector line toggles outside scan cycles
`timescale 1ns/1ps
module scan_partner
(
  input logic core_clk_i,
  input logic hidden_i,
  output logic sensor_o,
  output logic scan_strobe_o,
  output logic reflector_seen_o
);
  logic [1:0] cnt = 2'h0;
  always @(posedge core_clk_i) cnt <= cnt + 2'h1;
  assign sensor_o = hidden_i;
  assign scan_strobe_o = (cnt == 2'h3);
  // No steady level off scan, so stale values cannot pass
  assign reflector_seen_o = scan_strobe_o ? !hidden_i : cnt[0];
endmodule

/* verification/reading_trigger_control_tb_top.sv */
// Purpose: Self-checking bench for reading trigger control
// Assumes: Power sequence lengths cut to 10 cycles
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module reading_trigger_control_tb_top;
  import reading_trigger_pkg::*;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t value %h", $time, (a)); end end
  logic core_clk_i = 0, reset_i = 1, trig_src_reflector_i = 0, quality_mode_i = 0;
  logic hidden = 0, selftest_ok_i = 1, code_valid_i = 0, code_is_reflector_i = 0;
  logic [31:0] code_data_i = 32'h0;
  logic sensor_i, scan_strobe_i, reflector_seen_i, reading_pulse_o, laser_on_o;
  logic decode_enable_o, result_valid_o, beeper_o, ready_o;
  logic [31:0] result_data_o, result_tag_o;
  int failures = 0, total_checks = 0, beeps = 0, opened = 0, k;
  logic [1:0] rows [4] = '{2'b11, 2'b00, 2'b11, 2'b00};
  reading_trigger_control #(.SELFTEST_LEN(10), .BEEP_LEN(10)) reading_trigger_control_inst (.*);
  scan_partner scan_partner_inst (.core_clk_i(core_clk_i), .hidden_i(hidden),
    .sensor_o(sensor_i), .scan_strobe_o(scan_strobe_i), .reflector_seen_o(reflector_seen_i));
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge beeper_o) beeps++;
  always @(posedge core_clk_i) if (reading_pulse_o === 1'b1) opened = 1;
  task step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task powerup;
    beeps = 0;
    reset_i = 1;
    step(5);
    reset_i = 0;
    for (k = 0; k < 400 && ready_o !== 1'b1; k++) step(1);
  endtask
  task code(input logic [31:0] d, input logic refl);
    code_data_i = d;
    code_is_reflector_i = refl;
    code_valid_i = 1;
    step(1);
    code_valid_i = 0;
  endtask
  task end_sim;
    $display("failures=%0d total_checks=%0d", failures, total_checks);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #200000;
    failures++;
    end_sim();
  end
  initial
  begin
    powerup();
    `CHK(beeps, 3)
    `CHK(ready_o, 1'b1)
    `CHK(reading_pulse_o, 1'b0)
    for (int i = 0; i < 4; i++)
    begin
      hidden = rows[i][1];
      step(2);
      `CHK(reading_pulse_o, rows[i][0])
    end
    trig_src_reflector_i = 1;
    hidden = 1;
    powerup();
    opened = 0;
    step(200);
    `CHK(opened, 0)
    hidden = 0;
    step(100);
    `CHK(reading_pulse_o, 1'b0)
    hidden = 1;
    // 20 scans of 4 cycles stand in for the 25 ms bound
    for (k = 0; k < 84 && reading_pulse_o !== 1'b1; k++) step(1);
    `CHK(reading_pulse_o, 1'b1)
    code(32'h00c0ffee, 0);
    step(1);
    code(32'h0000beef, 1);
    hidden = 0;
    for (k = 0; k < 10 && result_valid_o !== 1'b1; k++) step(1);
    `CHK(result_data_o, 32'h00c0ffee)
    `CHK(result_tag_o, 32'h0)
    step(1);
    `CHK(reading_pulse_o, 1'b0)
    quality_mode_i = 1;
    step(1);
    `CHK(decode_enable_o, 1'b1)
    code(32'h12345678, 1);
    for (k = 0; k < 10 && result_valid_o !== 1'b1; k++) step(1);
    `CHK(result_tag_o, REFLECTOR_RESULT_TAG)
    `CHK(result_data_o, 32'h12345678)
    end_sim();
  end
endmodule
